// file: src/adc_glue_params.svh
// Function
// - Ring counter divides processor clock by four
// - Processor holds flag high, lowers to read
// - Frame sync falls 2 us after select
// - Port captures first bit on clock fall
// - I/O clock falls after each capture edge
// - 600 ns from shift edge to capture; the ring gives 100 ns
// - Processor port set for 8-bit words
// - Eighth capture takes LSB, raises interrupt
// - Handler reads result and raises flag
// - Without interrupt, raise flag after 44 cycles
// - Eighth I/O fall precedes select release
// - Flag stays high at least 17 us
// - Early select aborts, previous result shifts
// - Init enables only receive interrupt, flag first
// - Result read from 0, stored at 60h
`ifndef ADC_GLUE_PARAMS_SVH
`define ADC_GLUE_PARAMS_SVH
`define CLK_PERIOD_NS      50
`define RING_PHASES        4
`define FSYNC_DELAY_NS     2000
`define FSYNC_DELAY_CYC    ((`FSYNC_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SHIFT_TO_CAP_NS    600
`define WORD_BITS          8
`define FLAG_LOW_MIN_CYC   44
`define CONV_TIME_NS       17000
`define CONV_TIME_CYC      ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADC_RESET_VALUE    8'h00
`endif

// file: src/adc_glue_pkg.sv
package adc_glue_pkg;
   typedef enum logic [1:0] {ADC_IDLE, ADC_SHIFT, ADC_CONVERT} adc_state_t;
   typedef enum logic [1:0] {HOST_INIT, HOST_WAIT, HOST_HIGH} host_state_t;
   typedef logic [7:0] sample_t;
endpackage : adc_glue_pkg

// file: src/adc_glue_if.sv
`timescale 1ns/10ps
`default_nettype none
interface adc_glue_if;
   logic software_flag_output;   // Active-low converter select from the processor
   logic receive_frame_sync_n;
   logic receive_bit_clock;
   logic io_clock;
   logic adc_data;
   modport glue (input software_flag_output, output receive_frame_sync_n,
                 output receive_bit_clock, output io_clock, output adc_data);
   modport host (output software_flag_output, input receive_frame_sync_n,
                 input receive_bit_clock, input adc_data);
endinterface : adc_glue_if
`default_nettype wire

// file: src/adc_glue_device.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_glue_params.svh"
// Glue ring counter and frame sync delay plus a behavioural converter core
module adc_glue_device #(
   parameter int WORD_BITS = `WORD_BITS
) (
   input  wire logic              clock,
   input  wire logic              rst,
   adc_glue_if.glue               link,
   input  wire adc_glue_pkg::sample_t analog_sample,
   output logic                   conversion_busy
);
   import adc_glue_pkg::*;
   initial begin
      if (WORD_BITS != 8) $error("only 8-bit words are served");
   end

   localparam int FS_W = $clog2(`FSYNC_DELAY_CYC + 1);
   localparam int CV_W = $clog2(`CONV_TIME_CYC + 1);

   logic [3:0]      ring_ff;
   logic            sel_s1_ff, sel_s2_ff, sel_prev_ff;
   logic [FS_W-1:0] fs_cnt_ff;
   logic            fsync_n_ff;
   logic [3:0]      bit_cnt_ff;
   logic [CV_W-1:0] conv_cnt_ff;
   sample_t         result_ff, shift_ff;
   adc_state_t      state_ff;
   logic            io_fall;

   // Four-phase ring; phase 0 low is capture clock, phase 2 low is I/O clock
   always_ff @(posedge clock) begin
      if (rst) ring_ff <= 4'h1;
      else     ring_ff <= {ring_ff[2:0], ring_ff[3]};
   end
   // Receive clock falls as ring[0] sets; I/O clock falls two cycles later, as ring[2] sets
   // so a bit is stable 100 ns (two clock periods) before capture
   assign link.receive_bit_clock = ~(ring_ff[0] | ring_ff[1]);
   assign link.io_clock          = ~(ring_ff[2] | ring_ff[3]);
   assign io_fall                = ring_ff[1];

   // Select comes from the other party, so synchronise it
   always_ff @(posedge clock) begin
      if (rst) begin
         sel_s1_ff   <= 1'b1;
         sel_s2_ff   <= 1'b1;
         sel_prev_ff <= 1'b1;
      end else begin
         sel_s1_ff   <= link.software_flag_output;
         sel_s2_ff   <= sel_s1_ff;
         sel_prev_ff <= sel_s2_ff;
      end
   end

   // Frame sync delay; rearmed whenever select is high
   always_ff @(posedge clock) begin
      if (rst || sel_s2_ff) begin
         fs_cnt_ff  <= '0;
         fsync_n_ff <= 1'b1;
      end else if (fs_cnt_ff < FS_W'(`FSYNC_DELAY_CYC)) begin
         fs_cnt_ff <= fs_cnt_ff + 1'b1;
      end else if (ring_ff[3]) begin
         // Fall only ahead of a capture phase so no shift can precede bit one
         fsync_n_ff <= 1'b0;
      end
   end
   assign link.receive_frame_sync_n = fsync_n_ff;

   // Converter: shifts on I/O falls, converts after the eighth
   always_ff @(posedge clock) begin
      if (rst) begin
         state_ff    <= ADC_IDLE;
         bit_cnt_ff  <= '0;
         conv_cnt_ff <= '0;
         result_ff   <= `ADC_RESET_VALUE;
         shift_ff    <= `ADC_RESET_VALUE;
      end else if (!sel_s2_ff && sel_prev_ff) begin
         // Early select aborts a conversion; old result is kept
         state_ff   <= ADC_SHIFT;
         bit_cnt_ff <= '0;
         shift_ff   <= result_ff;
      end else begin
         unique case (state_ff)
            ADC_IDLE: begin
               if (conv_cnt_ff != '0) conv_cnt_ff <= conv_cnt_ff - 1'b1;
            end
            ADC_SHIFT: begin
               if (sel_s2_ff) begin
                  state_ff <= ADC_IDLE;   // Released before eighth edge
               end else if (io_fall && !fsync_n_ff) begin
                  shift_ff   <= {shift_ff[6:0], 1'b0};
                  bit_cnt_ff <= bit_cnt_ff + 1'b1;
                  if (bit_cnt_ff == 4'(WORD_BITS - 1)) begin
                     state_ff    <= ADC_CONVERT;
                     conv_cnt_ff <= CV_W'(`CONV_TIME_CYC);
                  end
               end
            end
            ADC_CONVERT: begin
               if (conv_cnt_ff == CV_W'(1)) begin
                  result_ff <= analog_sample;
                  state_ff  <= ADC_IDLE;
               end
               conv_cnt_ff <= conv_cnt_ff - 1'b1;
            end
         endcase
      end
   end
   assign link.adc_data   = shift_ff[7];
   assign conversion_busy = (state_ff == ADC_CONVERT);
endmodule : adc_glue_device
`default_nettype wire

// file: src/adc_glue_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_glue_params.svh"
// Processor serial receive port and flag sequencing
module adc_glue_host #(
   parameter int WORD_BITS = `WORD_BITS
) (
   input  wire logic             clock,
   input  wire logic             rst,
   adc_glue_if.host              link,
   input  wire logic             start,
   output adc_glue_pkg::sample_t result,
   output logic                  result_valid,
   output logic                  serial_receive_interrupt
);
   import adc_glue_pkg::*;
   initial begin
      if (WORD_BITS != 8) $error("only 8-bit words are served");
   end
   localparam int CV_W = $clog2(`CONV_TIME_CYC + 1);

   host_state_t     state_ff;
   logic            flag_ff, clk_prev_ff, irq_ff, valid_ff;
   logic [3:0]      cnt_ff;
   logic [CV_W-1:0] wait_ff;
   sample_t         rx_ff, result_ff;

   // Flag high at init, lowered on start after the conversion gap
   always_ff @(posedge clock) begin
      if (rst) begin
         state_ff <= HOST_INIT;
         flag_ff  <= 1'b1;
         wait_ff  <= CV_W'(`CONV_TIME_CYC);
         cnt_ff   <= '0;
         rx_ff    <= '0;
         irq_ff   <= 1'b0;
         result_ff <= '0;
         valid_ff <= 1'b0;
      end else begin
         irq_ff   <= 1'b0;
         valid_ff <= 1'b0;
         unique case (state_ff)
            HOST_INIT, HOST_HIGH: begin
               if (wait_ff != '0) wait_ff <= wait_ff - 1'b1;
               else if (start) begin
                  flag_ff  <= 1'b0;
                  cnt_ff   <= '0;
                  state_ff <= HOST_WAIT;
               end
            end
            HOST_WAIT: begin
               if (cnt_ff == 4'(WORD_BITS)) begin
                  // Keep select low until the eighth shift edge has passed
                  if (clk_prev_ff && link.receive_bit_clock) begin
                     flag_ff  <= 1'b1;
                     wait_ff  <= CV_W'(`CONV_TIME_CYC);
                     state_ff <= HOST_HIGH;
                  end
               // Capture on receive clock fall while frame sync low
               end else if (clk_prev_ff && !link.receive_bit_clock &&
                            !link.receive_frame_sync_n) begin
                  rx_ff  <= {rx_ff[6:0], link.adc_data};
                  cnt_ff <= cnt_ff + 1'b1;
                  if (cnt_ff == 4'(WORD_BITS - 1)) begin
                     irq_ff    <= 1'b1;
                     result_ff <= {rx_ff[6:0], link.adc_data};
                     valid_ff  <= 1'b1;
                  end
               end
            end
            default: state_ff <= HOST_INIT;
         endcase
      end
   end
   always_ff @(posedge clock) begin
      if (rst) clk_prev_ff <= 1'b0;
      else     clk_prev_ff <= link.receive_bit_clock;
   end
   assign link.software_flag_output = flag_ff;
   assign result                   = result_ff;
   assign result_valid             = valid_ff;
   assign serial_receive_interrupt = irq_ff;
endmodule : adc_glue_host
`default_nettype wire

// file: tb/glue_link_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_glue_params.svh"
module glue_link_asserts (
   input wire logic clock,
   input wire logic rst,
   input wire logic software_flag_output,
   input wire logic receive_frame_sync_n,
   input wire logic receive_bit_clock,
   input wire logic io_clock
);
   localparam logic [9:0] FS_CYC  = 10'(`FSYNC_DELAY_CYC);
   localparam logic [9:0] LOW_MIN = 10'(`FLAG_LOW_MIN_CYC);
   logic [9:0] low_cnt_ff;
   logic [9:0] high_cnt_ff;
   logic [3:0] bit_cnt_ff;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Saturating run lengths of select low and high
   always_ff @(posedge clock) begin
      if (rst || software_flag_output) low_cnt_ff <= 10'h000;
      else if (low_cnt_ff != 10'h3FF) low_cnt_ff <= low_cnt_ff + 10'h001;
   end
   always_ff @(posedge clock) begin
      if (rst || !software_flag_output) high_cnt_ff <= 10'h000;
      else if (high_cnt_ff != 10'h3FF) high_cnt_ff <= high_cnt_ff + 10'h001;
   end
   // Shift edges inside the frame; saturates so a slow host cannot wrap it
   always_ff @(posedge clock) begin
      if (rst || software_flag_output) bit_cnt_ff <= 4'h0;
      else if (!receive_frame_sync_n && $fell(io_clock) && bit_cnt_ff != 4'hF)
         bit_cnt_ff <= bit_cnt_ff + 4'h1;
   end
   property p_ring; $fell(io_clock) |-> ##4 $fell(io_clock); endproperty
   a_ring: assert property (p_ring) else $error("io clock period wrong");
   property p_shift; $fell(receive_bit_clock) |-> ##2 $fell(io_clock); endproperty
   a_shift: assert property (p_shift) else $error("shift edge misplaced");
   property p_fs_dly; $fell(receive_frame_sync_n) |-> low_cnt_ff >= FS_CYC; endproperty
   a_fs_dly: assert property (p_fs_dly) else $error("frame sync too early");
   property p_low; $rose(software_flag_output) |-> $past(low_cnt_ff) >= LOW_MIN; endproperty
   a_low: assert property (p_low) else $error("select low too short");
   property p_high; $fell(software_flag_output) |-> $past(high_cnt_ff) >= 10'h055; endproperty
   a_high: assert property (p_high) else $error("select high too short");
   property p_bits; $rose(software_flag_output) |-> $past(bit_cnt_ff) >= 4'h8; endproperty
   a_bits: assert property (p_bits) else $error("select released early");
   property p_rearm; $rose(software_flag_output) |-> ##[0:3] receive_frame_sync_n; endproperty
   a_rearm: assert property (p_rearm) else $error("frame sync not rearmed");
   property p_idle; software_flag_output [*4] |-> receive_frame_sync_n; endproperty
   a_idle: assert property (p_idle) else $error("frame sync low while idle");
   c_frame: cover property ($fell(receive_frame_sync_n));
   c_release: cover property ($rose(software_flag_output));
   c_eight: cover property (bit_cnt_ff == 4'h8);
endmodule : glue_link_asserts
`default_nettype wire

// file: tb/serial_adc_frame_glue_test.sv
`timescale 1ns/10ps
`default_nettype none
module serial_adc_frame_glue_test;
   import adc_glue_pkg::*;
   logic    clock = 1'b0;
   logic    rst = 1'b1;
   logic    start = 1'b0;
   sample_t analog_sample = 8'h00;
   sample_t result;
   logic    result_valid;
   logic    serial_receive_interrupt;
   logic    conversion_busy;
   logic    seen_irq = 1'b0;
   logic    seen_busy = 1'b0;
   int      fail_count = 0;
   int      checks = 0;
   sample_t table_v [5] = '{8'hA5, 8'h5A, 8'h00, 8'hFF, 8'h81};
   adc_glue_if link ();
   adc_glue_device u_adc_glue_device (.clock(clock), .rst(rst), .link(link),
      .analog_sample(analog_sample), .conversion_busy(conversion_busy));
   adc_glue_host u_adc_glue_host (.clock(clock), .rst(rst), .link(link), .start(start),
      .result(result), .result_valid(result_valid),
      .serial_receive_interrupt(serial_receive_interrupt));
   glue_link_asserts u_glue_link_asserts (.clock(clock), .rst(rst),
      .software_flag_output(link.software_flag_output),
      .receive_frame_sync_n(link.receive_frame_sync_n),
      .receive_bit_clock(link.receive_bit_clock), .io_clock(link.io_clock));
   always #25 clock = ~clock;
   // Sticky flags so a one-cycle pulse is not lost between samples
   always @(posedge clock) begin
      if (serial_receive_interrupt === 1'b1) seen_irq <= 1'b1;
      if (conversion_busy === 1'b1) seen_busy <= 1'b1;
   end
   task automatic check(input sample_t seen, input sample_t exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check
   task automatic tally_and_finish();
      if (fail_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   // Start is a level; it is held until the result shows, covering the refused gap
   task automatic read_once(output sample_t got);
      int n = 0;
      @(negedge clock) start = 1'b1;
      seen_irq = 1'b0;
      seen_busy = 1'b0;
      while (result_valid !== 1'b1 && n < 2000) begin
         @(posedge clock);
         #1 n++;
      end
      got = result;
      @(negedge clock) start = 1'b0;
      repeat (20) @(negedge clock);
   endtask : read_once
   // Cycle ceiling: ten reads of about 420 cycles plus the power-up gap
   initial begin
      repeat (10000) @(posedge clock);
      fail_count++;
      tally_and_finish();
   end
   // The first read of each pair primes the converter with the new sample
   initial begin
      sample_t got;
      repeat (3) @(negedge clock);
      rst = 1'b0;
      foreach (table_v[i]) begin
         analog_sample = table_v[i];
         read_once(got);
         read_once(got);
         check(got, table_v[i]);
         check({7'h00, seen_irq}, 8'h01);
         check({7'h00, seen_busy}, 8'h01);
      end
      tally_and_finish();
   end
endmodule : serial_adc_frame_glue_test
`default_nettype wire
